// ### hdl/ppr_regulator.sv
`timescale 1ns/1ps
`include "ppr_defines.svh"
module ppr_regulator #(
    parameter int BEAT_CYCLES = `PPR_BEAT_CYCLES
) (
    input  wire logic                clock_in,
    input  wire logic                sys_rst_in,
    input  wire logic [2:0]          target_source_select_in,
    input  wire logic [15:0]         digital_target_setting_in,
    input  wire logic [3:0]          feedback_source_select_in,
    input  wire ppr_pkg::ppr_sources_t sources_in,
    input  wire logic                action_direction_in,
    input  wire logic                dir_invert_term_in,
    input  wire logic [15:0]         display_range_in,
    input  wire ppr_pkg::ppr_gains_t gain_set1_in,
    input  wire ppr_pkg::ppr_gains_t gain_set2_in,
    input  wire logic [1:0]          gain_switch_condition_in,
    input  wire logic                gain_switch_term_in,
    input  wire logic [15:0]         switch_threshold_low_in,
    input  wire logic [15:0]         switch_threshold_high_in,
    input  wire logic [15:0]         reverse_cutoff_freq_in,
    input  wire logic                secondary_mode_in,
    input  wire logic [15:0]         deviation_dead_band_in,
    input  wire logic [15:0]         derivative_clamp_in,
    input  wire logic [15:0]         target_ramp_time_in,
    input  wire logic [15:0]         feedback_filter_time_in,
    input  wire logic [15:0]         output_filter_time_in,
    input  wire logic [15:0]         maximum_frequency_in,
    input  wire logic [15:0]         running_freq_in,
    output logic signed [31:0]       freq_cmd_out,
    output logic [15:0]              target_display_out,
    output logic [15:0]              feedback_display_out,
    output logic                     beat_out
);
    // ========================================================
    // Arithmetic helpers
    // ========================================================
    function automatic logic signed [31:0] sat(
        input logic signed [47:0] v, input logic signed [31:0] lim);
        if (v > 48'(lim))
            sat = lim;
        else if (v < -48'(lim))
            sat = -lim;
        else
            sat = v[31:0];
    endfunction

    function automatic logic signed [31:0] pct(input logic [15:0] v);
        pct = sat(48'($signed({16'h0, v})), `PPR_FULL);
    endfunction

    function automatic logic signed [31:0] lerp(
        input logic signed [31:0] a, input logic signed [31:0] b,
        input logic signed [31:0] x, input logic signed [31:0] lo,
        input logic signed [31:0] hi);
        logic signed [63:0] t;
        t = 64'(b - a) * 64'(x - lo);
        if (x <= lo)
            lerp = a;
        else if (x >= hi)
            lerp = b;
        else
            lerp = a + 32'(t / 64'(hi - lo));
    endfunction

    function automatic logic [15:0] scale_disp(
        input logic signed [31:0] v, input logic [15:0] range);
        logic [47:0] t;
        t = 48'(v) * 48'(range);
        scale_disp = 16'(t / 48'(`PPR_FULL));
    endfunction

    // ========================================================
    // Beat timing
    // ========================================================
    logic [31:0] beat_cnt_q;
    logic        tick0_q;
    logic        tick1_q;
    logic        tick2_q;

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            beat_cnt_q <= 32'h0;
            tick0_q    <= 1'b0;
        end else if (beat_cnt_q == 32'(BEAT_CYCLES - 1)) begin
            beat_cnt_q <= 32'h0;
            tick0_q    <= 1'b1;
        end else begin
            beat_cnt_q <= beat_cnt_q + 32'h1;
            tick0_q    <= 1'b0;
        end
    end

    // Three staged steps per beat: sources, regulator, output filter
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tick1_q  <= 1'b0;
            tick2_q  <= 1'b0;
            beat_out <= 1'b0;
        end else begin
            tick1_q  <= tick0_q;
            tick2_q  <= tick1_q;
            beat_out <= tick2_q;
        end
    end

    // ========================================================
    // Source selection
    // ========================================================
    logic signed [31:0] tgt_raw;
    logic signed [31:0] fb_raw;
    logic signed [31:0] an1;
    logic signed [31:0] an2;

    assign an1 = pct(sources_in.analog_in_first);
    assign an2 = pct(sources_in.analog_in_second);

    always_comb begin
        unique case (ppr_pkg::ppr_tsrc_t'(target_source_select_in))
            ppr_pkg::PPR_TS_PRESET: tgt_raw = pct(digital_target_setting_in);
            ppr_pkg::PPR_TS_AN1:    tgt_raw = an1;
            ppr_pkg::PPR_TS_AN2:    tgt_raw = an2;
            ppr_pkg::PPR_TS_AN3:    tgt_raw = pct(sources_in.analog_in_third);
            ppr_pkg::PPR_TS_PULSE:
                tgt_raw = pct(sources_in.pulse_input_terminal);
            ppr_pkg::PPR_TS_SERIAL: tgt_raw = pct(sources_in.serial_link);
            ppr_pkg::PPR_TS_MULTI:  tgt_raw = pct(sources_in.multi_step_ref);
            default:                tgt_raw = 32'sh0;
        endcase
    end

    // Combined feedbacks saturate into 0..100 percent
    always_comb begin
        unique case (ppr_pkg::ppr_fsrc_t'(feedback_source_select_in))
            ppr_pkg::PPR_FB_AN1:    fb_raw = an1;
            ppr_pkg::PPR_FB_AN2:    fb_raw = an2;
            ppr_pkg::PPR_FB_AN3:    fb_raw = pct(sources_in.analog_in_third);
            ppr_pkg::PPR_FB_DIFF:
                fb_raw = (an1 > an2) ? an1 - an2 : 32'sh0;
            ppr_pkg::PPR_FB_PULSE:
                fb_raw = pct(sources_in.pulse_input_terminal);
            ppr_pkg::PPR_FB_SERIAL: fb_raw = pct(sources_in.serial_link);
            ppr_pkg::PPR_FB_SUM:
                fb_raw = sat(48'(an1) + 48'(an2), `PPR_FULL);
            ppr_pkg::PPR_FB_MAX:    fb_raw = (an1 > an2) ? an1 : an2;
            ppr_pkg::PPR_FB_MIN:    fb_raw = (an1 < an2) ? an1 : an2;
            default:                fb_raw = 32'sh0;
        endcase
    end

    // ========================================================
    // Target ramp and feedback filter
    // ========================================================
    logic signed [31:0] ramp_q;
    logic signed [31:0] ramp_step;
    logic signed [31:0] ramp_div;
    logic signed [31:0] fb_filt;

    assign ramp_div = 32'(`PPR_BEATS_PER_CS)
                    * $signed({16'h0, target_ramp_time_in});
    assign ramp_step = (target_ramp_time_in == 16'h0) ? `PPR_FULL
                     : (`PPR_FULL + ramp_div - 32'sh1) / ramp_div;

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ramp_q <= 32'sh0;
        end else if (tick0_q) begin
            if (tgt_raw > ramp_q + ramp_step)
                ramp_q <= ramp_q + ramp_step;
            else if (tgt_raw < ramp_q - ramp_step)
                ramp_q <= ramp_q - ramp_step;
            else
                ramp_q <= tgt_raw;
        end
    end

    ppr_lowpass u_fb_filter (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .step_in    (tick0_q),
        .sample_in  (fb_raw),
        .time_cs_in (feedback_filter_time_in),
        .value_out  (fb_filt)
    );

    // ========================================================
    // Regulator terms
    // ========================================================
    logic               dir_rev;
    logic signed [31:0] err;
    logic signed [31:0] abs_err;
    logic signed [31:0] thr_lo;
    logic signed [31:0] thr_hi;
    logic signed [31:0] sw_x;
    logic               use_interp;
    logic               use_set2;
    logic signed [31:0] kp;
    logic signed [31:0] ti;
    logic signed [31:0] td;
    logic signed [31:0] p_term;
    logic signed [31:0] d_term;
    logic signed [31:0] d_lim;
    logic signed [31:0] pid_sum;
    logic signed [47:0] i_step;
    logic signed [47:0] i_next;
    logic signed [47:0] i_lim;
    logic signed [47:0] d_raw;
    logic               dead;
    logic signed [31:0] fmax;
    logic signed [31:0] freq_raw;
    logic signed [31:0] freq_cut;
    logic signed [47:0] integ_q;
    logic signed [31:0] fb_prev_q;
    logic signed [31:0] pid_freq_q;

    assign dir_rev = action_direction_in ^ dir_invert_term_in;
    // Error sign carries the action: forward raises on low feedback
    assign err = dir_rev ? fb_filt - ramp_q : ramp_q - fb_filt;
    assign abs_err = (err < 0) ? -err : err;
    assign dead = abs_err < pct(deviation_dead_band_in);

    // Low threshold is pulled down so it never passes the high one
    assign thr_hi = pct(switch_threshold_high_in);
    assign thr_lo = (pct(switch_threshold_low_in) > thr_hi) ? thr_hi
                  : pct(switch_threshold_low_in);
    assign use_set2 = (gain_switch_condition_in == 2'(ppr_pkg::PPR_SW_TERM))
                    && gain_switch_term_in;
    assign use_interp = gain_switch_condition_in[1];
    // Frequency switching reuses the thresholds on running/max percent
    assign sw_x = (gain_switch_condition_in == 2'(ppr_pkg::PPR_SW_FREQ))
                ? ((fmax == 0) ? 32'sh0 : sat(48'(running_freq_in)
                   * 48'(`PPR_FULL) / 48'(fmax), `PPR_FULL))
                : abs_err;

    always_comb begin
        if (use_interp) begin
            kp = lerp(32'(gain_set1_in.prop_gain),
                      32'(gain_set2_in.prop_gain), sw_x, thr_lo, thr_hi);
            ti = lerp(32'(gain_set1_in.integ_time),
                      32'(gain_set2_in.integ_time), sw_x, thr_lo, thr_hi);
            td = lerp(32'(gain_set1_in.deriv_time),
                      32'(gain_set2_in.deriv_time), sw_x, thr_lo, thr_hi);
        end else if (use_set2) begin
            kp = 32'(gain_set2_in.prop_gain);
            ti = 32'(gain_set2_in.integ_time);
            td = 32'(gain_set2_in.deriv_time);
        end else begin
            kp = 32'(gain_set1_in.prop_gain);
            ti = 32'(gain_set1_in.integ_time);
            td = 32'(gain_set1_in.deriv_time);
        end
    end

    assign p_term = sat(48'(err) * 48'(kp) / 48'(`PPR_GAIN_FULL),
                        `PPR_FULL);
    // Integral time of zero is outside the range; treat as one unit, 0.01 s (5 beats)
    assign i_step = (48'(err) <<< `PPR_FRAC)
                  / (48'(`PPR_BEATS_PER_CS) * 48'((ti == 0) ? 32'sh1 : ti));
    assign i_lim = 48'(`PPR_FULL) <<< `PPR_FRAC;
    assign i_next = (integ_q + i_step > i_lim) ? i_lim
                  : (integ_q + i_step < -i_lim) ? -i_lim
                  : integ_q + i_step;
    // Derivative acts on feedback only: no kick when the target moves
    assign d_raw = 48'(dir_rev ? fb_filt - fb_prev_q : fb_prev_q - fb_filt)
                 * 48'(td) / 48'(`PPR_BEAT_MS);
    assign d_lim = pct(derivative_clamp_in);
    assign d_term = sat(d_raw, d_lim);
    // Integer part read signed: a negative integral must pull the sum down
    assign pid_sum = sat(48'(p_term) + 48'($signed(integ_q[47:16]))
                         + 48'(d_term), `PPR_FULL);
    assign fmax = $signed({16'h0, maximum_frequency_in});
    assign freq_raw = 32'(48'(pid_sum) * 48'(fmax) / 48'(`PPR_FULL));
    assign freq_cut = (!secondary_mode_in
                       && freq_raw < -$signed({16'h0, reverse_cutoff_freq_in}))
                    ? -$signed({16'h0, reverse_cutoff_freq_in})
                    : freq_raw;

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            integ_q    <= '0;
            pid_freq_q <= 32'sh0;
        end else if (tick1_q && !dead) begin
            integ_q    <= i_next;
            pid_freq_q <= freq_cut;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            fb_prev_q <= 32'sh0;
        else if (tick1_q)
            fb_prev_q <= fb_filt;
    end

    // ========================================================
    // Output filter and displays
    // ========================================================
    ppr_lowpass u_out_filter (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .step_in    (tick2_q),
        .sample_in  (pid_freq_q),
        .time_cs_in (output_filter_time_in),
        .value_out  (freq_cmd_out)
    );

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            target_display_out   <= 16'h0;
            feedback_display_out <= 16'h0;
        end else if (tick1_q) begin
            target_display_out   <= scale_disp(ramp_q, display_range_in);
            feedback_display_out <= scale_disp(fb_filt, display_range_in);
        end
    end

    // ========================================================
    // Assertions
    // ========================================================
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    a_beat_stages: assert property (tick0_q |=> tick1_q ##1 tick2_q
        ##1 beat_out ##1 !beat_out)
        else $error("beat stages out of order");
    a_preset_target: assert property (target_source_select_in == 3'h0
        |-> tgt_raw == pct(digital_target_setting_in))
        else $error("preset target not selected");
    a_fb_minimum: assert property (feedback_source_select_in == 4'h8
        |-> fb_raw == ((an1 < an2) ? an1 : an2))
        else $error("feedback minimum wrong");
    a_ramp_step: assert property (tick0_q |=> (ramp_q - $past(ramp_q)
        <= $past(ramp_step)) && ($past(ramp_q) - ramp_q
        <= $past(ramp_step)))
        else $error("target ramp jumped");
    a_dead_hold: assert property (tick1_q && dead
        |=> $stable(pid_freq_q) && $stable(integ_q))
        else $error("output moved inside dead band");
    a_fwd_sign: assert property (!dir_rev && fb_filt < ramp_q
        |-> p_term >= 0)
        else $error("forward action sign wrong");
    a_rev_sign: assert property (dir_rev && fb_filt < ramp_q
        |-> p_term <= 0)
        else $error("reverse action sign wrong");
    a_deriv_clamp: assert property (d_term <= d_lim
        && d_term >= -d_lim)
        else $error("derivative beyond clamp");
    a_rev_cutoff: assert property (tick1_q && !dead
        && !secondary_mode_in
        |=> pid_freq_q >= -$signed({16'h0, $past(reverse_cutoff_freq_in)}))
        else $error("reverse cut-off exceeded");
    a_sum_clamp: assert property (pid_sum <= `PPR_FULL
        && pid_sum >= -`PPR_FULL)
        else $error("regulator sum beyond full scale");

    c_ramp_moving: cover property (tick0_q && tgt_raw != ramp_q);
    c_dead_hold: cover property (tick1_q && dead);
    c_cutoff_hit: cover property (tick1_q && !dead && freq_cut != freq_raw);
    c_interp_gain: cover property (use_interp && sw_x > thr_lo
        && sw_x < thr_hi);
endmodule

// ### hdl/ppr_defines.svh
`ifndef PPR_DEFINES_SVH
`define PPR_DEFINES_SVH
`define PPR_CLK_NS          10
`define PPR_BEAT_MS         2
`define PPR_BEAT_CYCLES     (`PPR_BEAT_MS * 1000000 / `PPR_CLK_NS)
`define PPR_CS_NS           10000000
`define PPR_BEATS_PER_CS    (`PPR_CS_NS / (`PPR_BEAT_MS * 1000000))
`define PPR_FULL            32'sh0000_2710
`define PPR_GAIN_FULL       32'sh0000_03e8
`define PPR_FRAC            16
`define PPR_DEF_TARGET      16'h1388
`define PPR_DEF_RANGE       16'h03e8
`define PPR_DEF_CUTOFF      16'h00c8
`define PPR_DEF_DCLAMP      16'h000a
`define PPR_DEF_THR_LOW     16'h07d0
`define PPR_DEF_THR_HIGH    16'h1f40
`endif

// ### hdl/ppr_pkg.sv
package ppr_pkg;
    typedef enum logic [2:0] {
        PPR_TS_PRESET, PPR_TS_AN1, PPR_TS_AN2, PPR_TS_AN3,
        PPR_TS_PULSE, PPR_TS_SERIAL, PPR_TS_MULTI
    } ppr_tsrc_t;
    typedef enum logic [3:0] {
        PPR_FB_AN1, PPR_FB_AN2, PPR_FB_AN3, PPR_FB_DIFF, PPR_FB_PULSE,
        PPR_FB_SERIAL, PPR_FB_SUM, PPR_FB_MAX, PPR_FB_MIN
    } ppr_fsrc_t;
    typedef enum logic [1:0] {
        PPR_SW_NONE, PPR_SW_TERM, PPR_SW_DEV, PPR_SW_FREQ
    } ppr_swmode_t;
    // Gain in 0.1 percent, integral time in 0.01 s, derivative time in 1 ms
    typedef struct packed {
        logic [15:0] prop_gain;
        logic [15:0] integ_time;
        logic [15:0] deriv_time;
    } ppr_gains_t;
    // All source signals in 0.01 percent units
    typedef struct packed {
        logic [15:0] analog_in_first;
        logic [15:0] analog_in_second;
        logic [15:0] analog_in_third;
        logic [15:0] pulse_input_terminal;
        logic [15:0] serial_link;
        logic [15:0] multi_step_ref;
    } ppr_sources_t;
endpackage

// ### hdl/ppr_lowpass.sv
`timescale 1ns/1ps
`include "ppr_defines.svh"
module ppr_lowpass (
    input  wire logic               clock_in,
    input  wire logic               sys_rst_in,
    input  wire logic               step_in,
    input  wire logic signed [31:0] sample_in,
    input  wire logic [15:0]        time_cs_in,
    output logic signed [31:0]      value_out
);
    logic signed [47:0] acc_q;
    logic signed [47:0] target_w;
    logic signed [47:0] div_w;

    assign target_w = 48'(sample_in) <<< `PPR_FRAC;
    assign div_w = 48'(`PPR_BEATS_PER_CS) * $signed({32'h0, time_cs_in});

    // Fractional accumulator keeps slow filters from stalling on small steps
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            acc_q <= '0;
        end else if (step_in) begin
            if (time_cs_in == 16'h0)
                acc_q <= target_w;
            else
                acc_q <= acc_q + (target_w - acc_q) / div_w;
        end
    end

    assign value_out = acc_q[47:16];
endmodule

// ### bench/ppr_source_model.sv
`timescale 1ns/1ps
// ==========================================
// Far-side source model
module ppr_source_model (
    input  wire logic                  clock_in,
    input  wire ppr_pkg::ppr_sources_t level_in,
    output ppr_pkg::ppr_sources_t      sources_out
);
    // Converters deliver one clock late, so the block never sees a
    // source change in the cycle the bench makes it
    always_ff @(posedge clock_in) begin
        sources_out <= level_in;
    end
endmodule

// ### bench/ppr_regulator_bench.sv
`timescale 1ns/1ps
module ppr_regulator_bench;
    logic                  clock_in, sys_rst_in, dir, inv, sec, term;
    logic [2:0]            tsel;
    logic [3:0]            fsel;
    logic [1:0]            swc;
    logic [15:0]           dig, range, band, ramp, fmax, tdisp, fdisp;
    logic [15:0]           cut, rfreq, oft, ffilt;
    ppr_pkg::ppr_gains_t   g1, g2;
    ppr_pkg::ppr_sources_t lvl, src;
    logic signed [31:0]    freq;
    logic                  beat;
    int                    n_mismatch = 0;
    int                    check_count = 0;
    ppr_source_model u_ppr_source_model (.clock_in(clock_in),
        .level_in(lvl), .sources_out(src));
    ppr_regulator #(.BEAT_CYCLES(16)) u_ppr_regulator (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .target_source_select_in(tsel), .digital_target_setting_in(dig),
        .feedback_source_select_in(fsel), .sources_in(src),
        .action_direction_in(dir), .dir_invert_term_in(inv),
        .display_range_in(range), .gain_set1_in(g1), .gain_set2_in(g2),
        .gain_switch_condition_in(swc), .gain_switch_term_in(term),
        .switch_threshold_low_in(16'h07d0),
        .switch_threshold_high_in(16'h1f40),
        .reverse_cutoff_freq_in(cut), .secondary_mode_in(sec),
        .deviation_dead_band_in(band), .derivative_clamp_in(16'h000a),
        .target_ramp_time_in(ramp), .feedback_filter_time_in(ffilt),
        .output_filter_time_in(oft), .maximum_frequency_in(fmax),
        .running_freq_in(rfreq), .freq_cmd_out(freq),
        .target_display_out(tdisp), .feedback_display_out(fdisp),
        .beat_out(beat));
    // ==========================================
    // Clock and checking helpers
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    task automatic print_verdict();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Integral creeps a unit or two in a few beats, hence the slack
    task automatic check_near(input logic signed [31:0] seen,
                              input logic signed [31:0] exp);
        check((seen - exp <= 2 && exp - seen <= 2) ? exp : seen, exp);
    endtask
    task automatic wait_beat(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(negedge clock_in);
                k++;
            end while (beat !== 1'b1 && k < 64);
            if (k >= 64) begin
                n_mismatch++;
                print_verdict();
            end
        end
    endtask
    task automatic restart();
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clock_in);
        sys_rst_in = 1'b0;
    endtask
    // Gain mode, target, derivative time, output filter, then n beats
    task automatic reg_case(input logic [1:0] s, input logic [15:0] d,
                            input logic [15:0] t, input logic [15:0] o,
                            input int n);
        swc = s;
        dig = d;
        g1.deriv_time = t;
        oft = o;
        restart();
        wait_beat(n);
    endtask
    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
    // ==========================================
    // Scenarios
    initial begin
        logic [15:0]        t_exp [7];
        logic [15:0]        f_exp [9];
        logic [4:0]         cfg [6];
        logic signed [31:0] q_exp [6];
        logic [15:0]        d1;
        time                t0;
        t_exp = '{16'h0898, 16'h0bb8, 16'h03e8, 16'h1b58, 16'h0fa0,
                  16'h1388, 16'h1770};
        f_exp = '{16'h0bb8, 16'h03e8, 16'h1b58, 16'h07d0, 16'h0fa0,
                  16'h1388, 16'h0fa0, 16'h0bb8, 16'h03e8};
        // Bits: dir, invert, secondary, terminal, dead band
        cfg = '{5'h00, 5'h14, 5'h10, 5'h08, 5'h02, 5'h01};
        q_exp = '{32'sd1000, -32'sd1000, -32'sd200, -32'sd200, 32'sd500,
                  32'sd0};
        {dir, inv, sec, term, swc, tsel, fsel} = '0;
        {band, ramp} = '0;
        {cut, rfreq, oft, ffilt} = {16'h00c8, 16'h0000, 16'h0000, 16'h0000};
        dig = 16'h0898;
        range = 16'h2710;
        fmax = 16'h1388;
        g1 = {16'h03e8, 16'h03e8, 16'h0000};
        g2 = {16'h01f4, 16'h03e8, 16'h0000};
        lvl = {16'h0bb8, 16'h03e8, 16'h1b58, 16'h0fa0, 16'h1388, 16'h1770};
        sys_rst_in = 1'b1;
        repeat (10) @(negedge clock_in);
        sys_rst_in = 1'b0;
        check(freq, 32'h0);
        check({tdisp, fdisp}, 32'h0);
        wait_beat(1);
        t0 = $time;
        wait_beat(1);
        check(32'(($time - t0) / 10), 32'h10);
        for (int i = 0; i < 9; i++) begin
            tsel = (i < 7) ? 3'(i) : 3'h0;
            fsel = 4'(i);
            wait_beat(2);
            if (i < 7) check(tdisp, t_exp[i]);
            check(fdisp, f_exp[i]);
        end
        range = 16'h07d0;
        tsel = 3'h0;
        wait_beat(2);
        check(tdisp, 16'h01b8);
        range = 16'h2710;
        dig = 16'h1770;
        fsel = 4'h4;
        for (int i = 0; i < 6; i++) begin
            {dir, inv, sec, term, band[13:12]} = {cfg[i][4:1], 1'b0,
                                                  cfg[i][0]};
            swc = {1'b0, cfg[i][1]};
            restart();
            wait_beat(3);
            check_near(freq, q_exp[i]);
        end
        {dir, inv, sec, term, swc, band} = '0;
        dig = 16'h2710;
        ramp = 16'h0001;
        restart();
        wait_beat(1);
        d1 = tdisp;
        wait_beat(1);
        check(tdisp - d1, 16'h07d0);
        ramp = 16'h0000;
        reg_case(2'h2, 16'h2328, 16'h0000, 16'h0000, 3);
        check(freq, 32'h0000_0754);
        rfreq = 16'h09c4;
        reg_case(2'h3, 16'h1770, 16'h0000, 16'h0000, 3);
        check(freq, 32'h0000_02ee);
        reg_case(2'h0, 16'h1770, 16'h03e8, 16'h0000, 1);
        check(freq, 32'h0000_03e3);
        reg_case(2'h0, 16'h1770, 16'h0000, 16'h0001, 3);
        check(freq, 32'h0000_01e8);
        {dir, cut} = {1'b1, 16'h0064};
        reg_case(2'h0, 16'h1770, 16'h0000, 16'h0000, 3);
        check(freq, 32'hffff_ff9c);
        {dir, ffilt} = {1'b0, 16'h0001};
        reg_case(2'h0, 16'h1770, 16'h0000, 16'h0000, 1);
        check(fdisp, 16'h0320);
        print_verdict();
    end
endmodule
